// >>> inc/vies_pkg.sv
// vme interrupt enable/status block: offsets, field layouts, reset values
// assumes an apb register bus with 32-bit data and byte addressing
package vies_pkg;
  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [11:0] OFF_ENABLE = 12'h310;
  localparam logic [11:0] OFF_STATUS = 12'h314;
  localparam logic [11:0] OFF_MAP_LINES = 12'h318;
  localparam logic [11:0] OFF_MAP_MISC = 12'h31c;
  localparam logic [11:0] OFF_MAP_MBOX = 12'h340;
  localparam logic [11:0] OFF_HOST_STAT = 12'h344;
  localparam logic [11:0] OFF_HOST_MASK = 12'h348;

  // ----------------------------------------------------------------
  // field positions and implemented-bit masks
  // ----------------------------------------------------------------
  localparam int SOFT_LVL_LSB = 25;
  localparam int MBOX_LSB = 16;
  localparam int GEN_SOFT_BIT = 12;
  localparam int VME_ERR_BIT = 10;
  localparam int PCI_ERR_BIT = 9;
  localparam int DMA_BIT = 8;
  localparam int GEN_SOFT_MAP_LSB = 16;
  localparam logic [31:0] IRQ_BITS_MASK = 32'hfe0f_17ff;
  localparam logic [31:0] MAP_LINES_MASK = 32'h7777_7777;
  localparam logic [31:0] MAP_MISC_MASK = 32'h0007_0777;
  localparam logic [15:0] MAP_MBOX_MASK = 16'h7777;
  localparam int HOST_EVT_W = 2;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] ENABLE_RST = 32'h0000_0000;
  localparam logic [31:0] STATUS_RST = 32'h0000_0000;
  localparam logic [31:0] MAP_RST = 32'h0000_0000;
  localparam logic [2:0] GEN_SOFT_MAP_STRAP = 3'h2;

  // ----------------------------------------------------------------
  // state of the top module
  // ----------------------------------------------------------------
  typedef struct packed {
    logic strap_done;
    logic [31:0] enable;
    logic [31:0] status;
    logic [31:0] map_lines;
    logic [31:0] map_misc;
    logic [15:0] map_mbox;
    logic [14:0] hist;
    logic [HOST_EVT_W-1:0] host_stat;
    logic [HOST_EVT_W-1:0] host_mask;
    logic host_irq;
    logic [6:0] vreq;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } vies_state_t;
endpackage

// >>> rtl/vies_map.sv
// level mapper: turns active sources and their 3-bit maps into level requests
// assumes map value 0 means no level and value n means level n
`timescale 1ns/1ps
module vies_map
  import vies_pkg::*;
#(
  parameter int NSRC = 16,
  parameter int LEVELS = 7
)(
  input wire logic [NSRC-1:0] act,
  input wire logic [3*NSRC-1:0] maps,
  output logic [LEVELS-1:0] req
);
  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  if (LEVELS < 1 || LEVELS > 7) begin : g_bad_levels
    $error("levels must be 1 to 7 for 3-bit maps");
  end

  logic [LEVELS-1:0][NSRC-1:0] hit;

  // ----------------------------------------------------------------
  // per level, per source match
  // ----------------------------------------------------------------
  for (genvar l = 0; l < LEVELS; l++)
  begin : g_lvl
    for (genvar s = 0; s < NSRC; s++)
    begin : g_src
      // a zero map never equals l+1, so it masks the source
      assign hit[l][s] = act[s] && (maps[3*s +: 3] == 3'(l + 1));
    end
    assign req[l] = |hit[l];
  end
endmodule // vies_map

// >>> rtl/vies_top.sv
// vme interrupt enable and status registers with level mapping and apb slave
// assumes inputs synchronous to CLK, apb master per amba spec, CE as clock enable
//
// Added by the designer: the APB slave port.
`timescale 1ns/1ps
module vies_top
  import vies_pkg::*;
#(
  parameter int ADDR_W = 12
)(
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic CE,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic AUTO_SLOT_POWERUP_OPTION,
  input wire logic [3:0] MAILBOX_IRQ,
  input wire logic VME_BUS_ERROR_IRQ,
  input wire logic PCI_BUS_ERROR_IRQ,
  input wire logic DMA_DONE_IRQ,
  input wire logic [7:0] PCI_IRQ_LINES,
  output logic [6:0] VME_IRQ_LEVEL_LINE,
  output logic HOST_IRQ
);
  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  if (ADDR_W < 10 || ADDR_W > 12) begin : g_bad_addr
    $error("address width must be 10 to 12 bits");
  end

  // ----------------------------------------------------------------
  // reset release through two flops
  // ----------------------------------------------------------------
  logic rst_meta_ff;
  logic rst_n;

  // async assert, sync release; only the second flop is used downstream
  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      rst_meta_ff <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_meta_ff <= 1'b1;
      rst_n <= rst_meta_ff;
    end
  end

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  vies_state_t q;
  vies_state_t nxt_q;
  logic [11:0] addr;
  logic acc;
  logic done;
  logic wr;
  logic sel_en;
  logic sel_st;
  logic sel_ml;
  logic sel_mm;
  logic sel_mb;
  logic sel_hs;
  logic sel_hm;
  logic hit;

  assign addr = 12'(PADDR);
  assign acc = CE && PSEL && PENABLE;
  // one wait state: the access cycle with pready high completes
  assign done = acc && q.pready;
  assign wr = done && PWRITE;
  assign sel_en = (addr == OFF_ENABLE);
  assign sel_st = (addr == OFF_STATUS);
  assign sel_ml = (addr == OFF_MAP_LINES);
  assign sel_mm = (addr == OFF_MAP_MISC);
  assign sel_mb = (addr == OFF_MAP_MBOX);
  assign sel_hs = (addr == OFF_HOST_STAT);
  assign sel_hm = (addr == OFF_HOST_MASK);
  assign hit = sel_en | sel_st | sel_ml | sel_mm | sel_mb | sel_hs | sel_hm;

  // ----------------------------------------------------------------
  // source edges and status set terms
  // ----------------------------------------------------------------
  logic [14:0] hw_lvl;
  logic [14:0] hw_rise;
  logic [31:0] new_en;
  logic [31:0] en_rise;
  logic [31:0] st_set;
  logic [31:0] st_clr;
  logic [31:0] rdata;

  // mailboxes 14:11, vme err 10, pci err 9, dma 8, pci lines 7:0
  assign hw_lvl = {MAILBOX_IRQ, VME_BUS_ERROR_IRQ, PCI_BUS_ERROR_IRQ, DMA_DONE_IRQ,
                   PCI_IRQ_LINES};
  assign hw_rise = hw_lvl & ~q.hist;
  assign new_en = (wr && sel_en) ? (PWDATA & IRQ_BITS_MASK) : q.enable;
  assign en_rise = new_en & ~q.enable;

  // soft sources latch on enable rise, hardware ones on input rise
  always_comb
  begin
    st_set = 32'h0;
    st_set[31:SOFT_LVL_LSB] = en_rise[31:SOFT_LVL_LSB];
    st_set[GEN_SOFT_BIT] = en_rise[GEN_SOFT_BIT];
    st_set[MBOX_LSB +: 4] = hw_rise[14:11];
    st_set[VME_ERR_BIT] = hw_rise[10];
    st_set[PCI_ERR_BIT] = hw_rise[9];
    st_set[DMA_BIT] = hw_rise[8];
    st_set[7:0] = hw_rise[7:0];
  end

  // clear never touches the source, only the latch
  assign st_clr = (wr && sel_st) ? PWDATA : 32'h0;

  // ----------------------------------------------------------------
  // level mapping
  // ----------------------------------------------------------------
  logic [31:0] active;
  logic [15:0] map_act;
  logic [47:0] map_sel;
  logic [6:0] map_req;
  logic [6:0] req_c;

  assign active = q.status & q.enable;
  assign map_act = {active[19:16], active[GEN_SOFT_BIT], active[10:8], active[7:0]};
  assign map_sel = {q.map_mbox[14:12], q.map_mbox[10:8], q.map_mbox[6:4],
                    q.map_mbox[2:0], q.map_misc[18:16], q.map_misc[10:8],
                    q.map_misc[6:4], q.map_misc[2:0], q.map_lines[30:28],
                    q.map_lines[26:24], q.map_lines[22:20], q.map_lines[18:16],
                    q.map_lines[14:12], q.map_lines[10:8], q.map_lines[6:4],
                    q.map_lines[2:0]};

  vies_map #(
    .NSRC(16),
    .LEVELS(7)
  ) u_map (
    .act(map_act),
    .maps(map_sel),
    .req(map_req)
  );

  // soft level n always lands on level n, no map involved
  assign req_c = map_req | active[31:SOFT_LVL_LSB];

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  always_comb
  begin
    rdata = 32'h0;
    if (sel_en)
      rdata = q.enable;
    if (sel_st)
      rdata = q.status;
    if (sel_ml)
      rdata = q.map_lines;
    if (sel_mm)
      rdata = q.map_misc;
    if (sel_mb)
      rdata = {16'h0, q.map_mbox};
    if (sel_hs)
      rdata = {{(32 - HOST_EVT_W){1'b0}}, q.host_stat};
    if (sel_hm)
      rdata = {{(32 - HOST_EVT_W){1'b0}}, q.host_mask};
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  logic [HOST_EVT_W-1:0] host_set;

  // bit0: a new status latch, bit1: access to an unmapped address
  assign host_set = {done && !hit, |(st_set & ~q.status & IRQ_BITS_MASK)};

  always_comb
  begin
    nxt_q = q;
    nxt_q.hist = hw_lvl;
    nxt_q.enable = new_en;
    // set wins over a same-cycle write-one clear
    nxt_q.status = ((q.status & ~st_clr) | st_set) & IRQ_BITS_MASK;
    if (wr && sel_ml)
      nxt_q.map_lines = PWDATA & MAP_LINES_MASK;
    if (wr && sel_mm)
      nxt_q.map_misc = PWDATA & MAP_MISC_MASK;
    if (wr && sel_mb)
      nxt_q.map_mbox = PWDATA[15:0] & MAP_MBOX_MASK;
    if (wr && sel_hm)
      nxt_q.host_mask = PWDATA[HOST_EVT_W-1:0];
    // read clears host events; a new event in that cycle survives
    if (done && !PWRITE && sel_hs)
      nxt_q.host_stat = host_set;
    else
      nxt_q.host_stat = q.host_stat | host_set;
    // strap is caught in the first enabled cycle after reset release
    if (!q.strap_done)
    begin
      nxt_q.strap_done = 1'b1;
      nxt_q.enable[GEN_SOFT_BIT] = AUTO_SLOT_POWERUP_OPTION;
      nxt_q.status[GEN_SOFT_BIT] = AUTO_SLOT_POWERUP_OPTION;
      if (AUTO_SLOT_POWERUP_OPTION)
        nxt_q.map_misc[GEN_SOFT_MAP_LSB +: 3] = GEN_SOFT_MAP_STRAP;
    end
    nxt_q.host_irq = |(nxt_q.host_stat & nxt_q.host_mask);
    nxt_q.vreq = req_c;
    // apb: answer one cycle into the access phase
    nxt_q.pready = acc && !q.pready;
    nxt_q.pslverr = acc && !q.pready && !hit;
    if (acc && !q.pready)
      nxt_q.prdata = PWRITE ? 32'h0 : rdata;
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      q <= '0;
      q.enable <= ENABLE_RST;
      q.status <= STATUS_RST;
      q.map_lines <= MAP_RST;
      q.map_misc <= MAP_RST;
    end
    else if (CE)
      q <= nxt_q;
  end

  assign PRDATA = q.prdata;
  assign PREADY = q.pready;
  assign PSLVERR = q.pslverr;
  assign VME_IRQ_LEVEL_LINE = q.vreq;
  assign HOST_IRQ = q.host_irq;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  logic wr_en_c;
  logic wr_st_c;

  assign wr_en_c = wr && sel_en;
  assign wr_st_c = wr && sel_st;

  chk_soft_rise_sets: assert property (@(posedge CLK) disable iff (!rst_n)
    ((q.enable[31:25] & ~$past(q.enable[31:25]) & ~q.status[31:25]) == 7'h0))
    else $error("soft level enable rose without status set");

  chk_soft_fall_keeps: assert property (@(posedge CLK) disable iff (!rst_n)
    CE && wr_en_c && q.enable[31] && !PWDATA[31] |=> !q.enable[31] &&
    (q.status[31] == $past(q.status[31])))
    else $error("clearing soft enable changed status");

  chk_mbox_level: assert property (@(posedge CLK) disable iff (!rst_n)
    CE && q.enable[16] && q.status[16] && q.map_mbox[2:0] == 3'h6 |=> VME_IRQ_LEVEL_LINE[5])
    else $error("enabled mailbox did not request its level");

  chk_gen_soft_rise: assert property (@(posedge CLK) disable iff (!rst_n)
    $rose(q.enable[12]) |-> q.status[12])
    else $error("general soft enable rose without status");

  chk_dma_level: assert property (@(posedge CLK) disable iff (!rst_n)
    CE && q.enable[8] && q.status[8] && q.map_misc[2:0] == 3'h1 |=> VME_IRQ_LEVEL_LINE[0])
    else $error("enabled dma did not request level 1");

  chk_line_level: assert property (@(posedge CLK) disable iff (!rst_n)
    CE && q.enable[0] && q.status[0] && q.map_lines[2:0] == 3'h3 |=> VME_IRQ_LEVEL_LINE[2])
    else $error("enabled pci line did not request level 3");

  chk_masked_quiet: assert property (@(posedge CLK) disable iff (!rst_n)
    CE && q.enable == 32'h0 |=> VME_IRQ_LEVEL_LINE == 7'h0)
    else $error("request with every source disabled");

  chk_zero_map: assert property (@(posedge CLK) disable iff (!rst_n)
    CE && q.map_lines == 32'h0 && q.map_misc == 32'h0 && q.map_mbox == 16'h0 &&
    q.enable[31:25] == 7'h0 |=> VME_IRQ_LEVEL_LINE == 7'h0)
    else $error("request from an unmapped source");

  chk_write_zero: assert property (@(posedge CLK) disable iff (!rst_n)
    CE && wr_st_c && !PWDATA[31] && q.status[31] |=> q.status[31])
    else $error("writing zero cleared a status bit");

  chk_edge_latch: assert property (@(posedge CLK) disable iff (!rst_n)
    CE && VME_BUS_ERROR_IRQ && !q.hist[10] |=> q.status[10] [*1])
    else $error("vme error edge not latched");

  chk_w1c_clear: assert property (@(posedge CLK) disable iff (!rst_n)
    CE && wr_st_c && PWDATA[10] && !hw_rise[10] |=> !q.status[10])
    else $error("write one did not clear vme error status");

  chk_reserved_zero: assert property (@(posedge CLK) disable iff (!rst_n)
    (q.status & ~IRQ_BITS_MASK) == 32'h0 && (q.enable & ~IRQ_BITS_MASK) == 32'h0)
    else $error("reserved bit set");

  cov_soft_req: cover property (@(posedge CLK) disable iff (!rst_n)
    $rose(VME_IRQ_LEVEL_LINE[1]));
  cov_mbox_clear: cover property (@(posedge CLK) disable iff (!rst_n)
    q.status[16] ##1 !q.status[16]);
  cov_host_irq: cover property (@(posedge CLK) disable iff (!rst_n)
    $rose(HOST_IRQ));
  cov_slverr: cover property (@(posedge CLK) disable iff (!rst_n)
    PREADY && PSLVERR);
endmodule // vies_top

// >>> testbench/tb_vies_top.sv
// self-checking bench for vies_top: apb master tasks and one task per scenario
// assumes the one wait state apb slave and offsets of vies_pkg
`timescale 1ns/1ps
module tb_vies_top
  import vies_pkg::*;
;
  logic clk, resetn, strap, psel, penable, pwrite, serr, ready_seen;
  logic vme_bus_error_irq, perr, dma, pready, pslverr, host_irq, ce;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] mbox;
  logic [7:0] lines;
  logic [6:0] vlines;
  logic [2:0] top_lvl;
  int num_errors, tests_run;

  // ----------------------------------------------------------------
  // clock, design and far side
  // ----------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // clock enable is dropped by one scenario to check that state freezes
  vies_top vies_top_inst (.CLK(clk), .RESETN(resetn), .CE(ce), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .AUTO_SLOT_POWERUP_OPTION(strap),
    .MAILBOX_IRQ(mbox), .VME_BUS_ERROR_IRQ(vme_bus_error_irq), .PCI_BUS_ERROR_IRQ(perr),
    .DMA_DONE_IRQ(dma), .PCI_IRQ_LINES(lines), .VME_IRQ_LEVEL_LINE(vlines),
    .HOST_IRQ(host_irq));

  vies_handler vies_handler_inst (.irq_lines(vlines), .top_lvl(top_lvl));

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic end_of_test();
    if (num_errors == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // request held until pready is seen high; data taken at that same edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    ready_seen = 1'b0;
    repeat (20)
      if (!ready_seen)
      begin
        @(posedge clk);
        ready_seen = (pready === 1'b1);
        rd = prdata;
        serr = pslverr;
      end
    psel <= 1'b0;
    penable <= 1'b0;
    if (!ready_seen)
    begin
      num_errors++;
      end_of_test();
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdchk(input string what, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(what, exp, rd);
  endtask

  // level outputs follow a status change one edge later
  task automatic settle();
    repeat (2) @(posedge clk);
  endtask

  task automatic do_reset(input logic s);
    @(posedge clk);
    resetn <= 1'b0;
    strap <= s;
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    repeat (4) @(posedge clk);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset_and_all();
    rdchk("enable", OFF_ENABLE, ENABLE_RST);
    rdchk("status", OFF_STATUS, STATUS_RST);
    wr(OFF_ENABLE, 32'hffff_ffff);
    rdchk("enable", OFF_ENABLE, 32'hfe0f_17ff);
    rdchk("status", OFF_STATUS, 32'hfe00_1000);
    chk("levels", 32'h7f, 32'(vlines));
    wr(OFF_ENABLE, 32'h0);
    settle();
    chk("levels", 32'h0, 32'(vlines));
    wr(OFF_STATUS, 32'h0);
    rdchk("status", OFF_STATUS, 32'hfe00_1000);
    wr(OFF_STATUS, 32'hffff_ffff);
    rdchk("status", OFF_STATUS, 32'h0);
  endtask

  task automatic t_soft_levels();
    for (int n = 1; n <= 7; n++)
    begin
      wr(OFF_ENABLE, 32'h1 << (24 + n));
      settle();
      chk("level", 32'h1 << (n - 1), 32'(vlines));
      chk("served", 32'(n), 32'(top_lvl));
      wr(OFF_ENABLE, 32'h0);
      wr(OFF_STATUS, 32'h1 << (24 + n));
    end
  endtask

  task automatic t_general_soft();
    wr(OFF_MAP_MISC, 32'h0007_0000);
    wr(OFF_ENABLE, 32'h0000_1000);
    settle();
    chk("levels", 32'h40, 32'(vlines));
    wr(OFF_ENABLE, 32'h0);
    settle();
    chk("levels", 32'h0, 32'(vlines));
    rdchk("status", OFF_STATUS, 32'h0000_1000);
    wr(OFF_STATUS, 32'h0000_1000);
    rdchk("status", OFF_STATUS, 32'h0);
  endtask

  // sources stay high across the clear: no new edge, so no new status
  task automatic t_hw_sources();
    wr(OFF_MAP_LINES, 32'h0000_0003);
    wr(OFF_MAP_MISC, 32'h0000_0451);
    wr(OFF_MAP_MBOX, 32'h0000_0006);
    @(posedge clk);
    mbox <= 4'hf;
    vme_bus_error_irq <= 1'b1;
    perr <= 1'b1;
    dma <= 1'b1;
    lines <= 8'hff;
    settle();
    rdchk("status", OFF_STATUS, 32'h000f_07ff);
    chk("levels", 32'h0, 32'(vlines));
    wr(OFF_ENABLE, 32'h000f_07ff);
    settle();
    chk("levels", 32'h3d, 32'(vlines));
    chk("served", 32'h6, 32'(top_lvl));
    wr(OFF_STATUS, 32'hffff_ffff);
    rdchk("status", OFF_STATUS, 32'h0);
    chk("levels", 32'h0, 32'(vlines));
    @(posedge clk);
    {mbox, vme_bus_error_irq, perr, dma, lines} <= '0;
    @(posedge clk);
    perr <= 1'b1;
    @(posedge clk);
    perr <= 1'b0;
    settle();
    rdchk("status", OFF_STATUS, 32'h0000_0200);
    chk("levels", 32'h10, 32'(vlines));
    wr(OFF_ENABLE, 32'h0000_0001);
    settle();
    chk("levels", 32'h0, 32'(vlines));
    wr(OFF_STATUS, 32'h0000_0200);
  endtask

  // an edge that arrives while CE is low is only seen once CE returns
  task automatic t_clock_enable();
    wr(OFF_ENABLE, 32'h0000_0100);
    @(posedge clk);
    ce <= 1'b0;
    dma <= 1'b1;
    repeat (4) @(posedge clk);
    chk("levels", 32'h0, 32'(vlines));
    ce <= 1'b1;
    repeat (3) @(posedge clk);
    chk("levels", 32'h1, 32'(vlines));
    dma <= 1'b0;
    rdchk("status", OFF_STATUS, 32'h0000_0100);
    wr(OFF_STATUS, 32'h0000_0100);
    wr(OFF_ENABLE, 32'h0);
  endtask

  task automatic t_host_irq();
    wr(OFF_HOST_MASK, 32'h2);
    apb(1'b0, 12'h300, 32'h0);
    chk("slverr", 32'h1, 32'(serr));
    chk("unmapped", 32'h0, rd);
    @(posedge clk);
    chk("host_irq", 32'h1, 32'(host_irq));
    apb(1'b0, OFF_HOST_STAT, 32'h0);
    chk("host_stat", 32'h2, rd & 32'h2);
    settle();
    chk("host_irq", 32'h0, 32'(host_irq));
    wr(OFF_HOST_MASK, 32'h0);
    apb(1'b1, 12'h300, 32'h0);
    settle();
    chk("host_irq", 32'h0, 32'(host_irq));
  endtask

  task automatic t_strap();
    do_reset(1'b1);
    rdchk("enable", OFF_ENABLE, 32'h0000_1000);
    rdchk("status", OFF_STATUS, 32'h0000_1000);
    rdchk("map", OFF_MAP_MISC, 32'h0002_0000);
    chk("levels", 32'h02, 32'(vlines));
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    num_errors = 0;
    tests_run = 0;
    {strap, psel, penable, pwrite, vme_bus_error_irq, perr, dma} = '0;
    ce = 1'b1;
    // nba so the drop from unknown is seen as a reset edge at time zero
    resetn <= 1'b0;
    {paddr, pwdata, mbox, lines} = '0;
    do_reset(1'b0);
    t_reset_and_all();
    t_soft_levels();
    t_general_soft();
    t_hw_sources();
    t_clock_enable();
    t_host_irq();
    t_strap();
    end_of_test();
  end
endmodule // tb_vies_top

// >>> testbench/vies_handler.sv
// far-side model: a vme interrupt handler watching the seven request levels
// assumes levels are active high and settled between clock edges
`timescale 1ns/1ps
module vies_handler (
  input wire logic [6:0] irq_lines,
  output logic [2:0] top_lvl
);
  // ----------------------------------------------------------------
  // priority pick
  // ----------------------------------------------------------------
  // the handler serves the highest level first; an unknown line is never served
  always_comb
  begin
    top_lvl = 3'h0;
    for (int i = 0; i < 7; i++)
      if (irq_lines[i] === 1'b1)
        top_lvl = 3'(i + 1);
  end
endmodule // vies_handler
